// [rtl/csb_alu_top.v]
// execution datapath of an 8/16-bit core behind an axi4-lite slave
// assumes one clock, synchronous active-low reset, a well-behaved bus master
//
// Summary of operation
// RL1: add stores sum, carry, zero, nibble flags
// RL2: add with carry includes prior carry
// RL3: subtract stores difference, borrow into carry
// RL4: subtract with borrow also subtracts carry
// RL5: logic ops update zero flag only
// RL6: compares set flags, write no operand
// RL7: word add/subtract on word accumulator
// RL8: multiply into word accumulator, flags kept
// RL9: divide: quotient accumulator, remainder register
// RL10: zero divisor: copy low byte, all ones
// RL11: byte increment/decrement keep carry flag
// RL12: pair increment/decrement keep all flags
// RL13: rotate right n times through bit seven
// RL14: rotate left n times into bit zero
// RL15: rotate right through carry n steps
// RL16: rotate left through carry n steps
// RL17: byte shifts zero fill, clear nibble flag
// RL18: pair shifts zero fill, update zero
// RL19: nibble rotate right through memory byte
// RL20: nibble rotate left through memory byte
// RL21: decimal adjust after add or subtract
// RL22: bit and combines carry with bit
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "csb_alu_map.vh"

module csb_alu_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    // ****************
    // state
    // ****************
    reg awready_ff;
    reg wready_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg arready_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;
    reg aw_hold_ff;
    reg [7:0] awaddr_ff;
    reg w_hold_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg [15:0] dest_ff;
    reg [15:0] src_ff;
    reg carry_ff;
    reg nib_ff;
    reg zero_ff;
    reg [11:0] cmd_ff;
    reg [15:0] count_ff;
    reg bad_ff;

    // ****************
    // write decode
    // ****************
    wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire wr_dest = do_write & (awaddr_ff == `CSB_OFF_DEST);
    wire wr_src = do_write & (awaddr_ff == `CSB_OFF_SRC);
    wire wr_flags = do_write & (awaddr_ff == `CSB_OFF_FLAGS) & wstrb_ff[0];
    wire wr_cmd = do_write & (awaddr_ff == `CSB_OFF_CMD);
    wire wr_stat = do_write & (awaddr_ff == `CSB_OFF_STATUS);
    // address is word aligned, so every offset up to status is mapped
    wire wr_hit = (awaddr_ff <= `CSB_OFF_STATUS);

    // an operation runs only when the opcode byte is written
    wire exec = wr_cmd & wstrb_ff[0];

    wire [4:0] op = wdata_ff[`CSB_CMD_OP_MSB:`CSB_CMD_OP_LSB];
    wire [2:0] cnt = wdata_ff[`CSB_CMD_CNT_MSB:`CSB_CMD_CNT_LSB];
    wire inv = wdata_ff[`CSB_CMD_INV];

    // ****************
    // shared arithmetic
    // ****************
    wire [7:0] a8 = dest_ff[7:0];
    wire [7:0] b8 = src_ff[7:0];
    wire use_cy = (op == `CSB_OP_ADD_CY) | (op == `CSB_OP_SUB_BW);
    wire cin = use_cy & carry_ff;
    wire [8:0] sum9 = {1'b0, a8} + {1'b0, b8} + {8'h00, cin};
    wire [4:0] sum5 = {1'b0, a8[3:0]} + {1'b0, b8[3:0]} + {4'h0, cin};
    wire [8:0] dif9 = {1'b0, a8} - {1'b0, b8} - {8'h00, cin};
    wire [4:0] dif5 = {1'b0, a8[3:0]} - {1'b0, b8[3:0]} - {4'h0, cin};
    wire [16:0] wsum = {1'b0, dest_ff} + {1'b0, src_ff};
    wire [16:0] wdif = {1'b0, dest_ff} - {1'b0, src_ff};
    wire [4:0] wnsum = {1'b0, dest_ff[3:0]} + {1'b0, src_ff[3:0]};
    wire [4:0] wndif = {1'b0, dest_ff[3:0]} - {1'b0, src_ff[3:0]};
    wire [8:0] inc9 = {1'b0, a8} + 9'h001;
    wire [8:0] dec9 = {1'b0, a8} - 9'h001;
    wire [15:0] prod = dest_ff[15:8] * b8;

    // ****************
    // decimal adjust
    // ****************
    wire daa_lo = nib_ff | (a8[3:0] > 4'h9);
    wire daa_hi = carry_ff | (a8 > 8'h99);
    wire [4:0] daa_n = {1'b0, a8[3:0]} + (daa_lo ? 5'h06 : 5'h00);
    wire [8:0] daa_r = {1'b0, a8} + (daa_lo ? 9'h006 : 9'h000) +
                       (daa_hi ? 9'h060 : 9'h000);
    wire [4:0] das_n = {1'b0, a8[3:0]} - (nib_ff ? 5'h06 : 5'h00);
    wire [7:0] das_r = a8 - (nib_ff ? 8'h06 : 8'h00) - (carry_ff ? 8'h60 : 8'h00);

    // ****************
    // rotator and divider
    // ****************
    wire rot_wide = (op == `CSB_OP_PSH_R) | (op == `CSB_OP_PSH_L);
    wire rot_left = (op == `CSB_OP_ROT_L) | (op == `CSB_OP_RTC_L) |
                    (op == `CSB_OP_LSH_L) | (op == `CSB_OP_PSH_L);
    wire [1:0] rot_mode = ((op == `CSB_OP_ROT_R) | (op == `CSB_OP_ROT_L)) ?
                          `CSB_RMODE_ROT :
                          (((op == `CSB_OP_RTC_R) | (op == `CSB_OP_RTC_L)) ?
                          `CSB_RMODE_RTC : `CSB_RMODE_ZERO);
    wire [15:0] rot_in = rot_wide ? dest_ff : {8'h00, a8};
    wire [15:0] rot_out;
    wire rot_cy;
    wire [15:0] quot;
    wire [7:0] rem;

    csb_rotator #(
        .STEPS(7)
    ) u_rot (
        .din(rot_in),
        .cin(carry_ff),
        .wide(rot_wide),
        .mode(rot_mode),
        .left(rot_left),
        .count(cnt),
        .dout(rot_out),
        .cout(rot_cy)
    );

    csb_divider #(
        .DW(16),
        .VW(8)
    ) u_div (
        .dividend(dest_ff),
        .divisor(b8),
        .quotient(quot),
        .remainder(rem)
    );

    wire sel_bit = src_ff[cnt] ^ inv;

    // ****************
    // operation select
    // ****************
    reg [15:0] nxt_dest;
    reg [15:0] nxt_src;
    reg nxt_carry;
    reg nxt_nib;
    reg nxt_zero;
    reg nxt_bad;

    always @* begin
        nxt_dest = dest_ff;
        nxt_src = src_ff;
        nxt_carry = carry_ff;
        nxt_nib = nib_ff;
        nxt_zero = zero_ff;
        nxt_bad = 1'b0;
        case (op)
            `CSB_OP_ADD, `CSB_OP_ADD_CY: begin
                nxt_dest = {dest_ff[15:8], sum9[7:0]}; // see RL1 see RL2
                nxt_carry = sum9[8];
                nxt_nib = sum5[4];
                nxt_zero = (sum9[7:0] == 8'h00);
            end
            `CSB_OP_SUB, `CSB_OP_SUB_BW: begin
                nxt_dest = {dest_ff[15:8], dif9[7:0]}; // see RL3 see RL4
                nxt_carry = dif9[8];
                nxt_nib = dif5[4];
                nxt_zero = (dif9[7:0] == 8'h00);
            end
            `CSB_OP_AND: begin
                nxt_dest = {dest_ff[15:8], a8 & b8}; // see RL5
                nxt_zero = ((a8 & b8) == 8'h00);
            end
            `CSB_OP_OR: begin
                nxt_dest = {dest_ff[15:8], a8 | b8}; // see RL5
                nxt_zero = ((a8 | b8) == 8'h00);
            end
            `CSB_OP_XOR: begin
                nxt_dest = {dest_ff[15:8], a8 ^ b8}; // see RL5
                nxt_zero = ((a8 ^ b8) == 8'h00);
            end
            `CSB_OP_BCOMP: begin
                nxt_carry = dif9[8]; // see RL6
                nxt_nib = dif5[4];
                nxt_zero = (dif9[7:0] == 8'h00);
            end
            `CSB_OP_WADD: begin
                nxt_dest = wsum[15:0]; // see RL7
                nxt_carry = wsum[16];
                nxt_nib = wnsum[4];
                nxt_zero = (wsum[15:0] == 16'h0000);
            end
            `CSB_OP_WSUB, `CSB_OP_WCOMP: begin
                if (op == `CSB_OP_WSUB) begin
                    nxt_dest = wdif[15:0]; // see RL7
                end
                nxt_carry = wdif[16]; // see RL6
                nxt_nib = wndif[4];
                nxt_zero = (wdif[15:0] == 16'h0000);
            end
            `CSB_OP_MUL: begin
                nxt_dest = prod; // see RL8
            end
            `CSB_OP_DIV: begin
                if (b8 == 8'h00) begin
                    nxt_dest = 16'hFFFF; // see RL10
                    nxt_src = {src_ff[15:8], a8};
                end else begin
                    nxt_dest = quot; // see RL9
                    nxt_src = {src_ff[15:8], rem};
                end
            end
            `CSB_OP_INC: begin
                nxt_dest = {dest_ff[15:8], inc9[7:0]}; // see RL11
                nxt_nib = (a8[3:0] == 4'hF);
                nxt_zero = (inc9[7:0] == 8'h00);
            end
            `CSB_OP_DEC: begin
                nxt_dest = {dest_ff[15:8], dec9[7:0]}; // see RL11
                nxt_nib = (a8[3:0] == 4'h0);
                nxt_zero = (dec9[7:0] == 8'h00);
            end
            `CSB_OP_PINC: begin
                nxt_dest = dest_ff + 16'h0001; // see RL12
            end
            `CSB_OP_PDEC: begin
                nxt_dest = dest_ff - 16'h0001; // see RL12
            end
            `CSB_OP_ROT_R, `CSB_OP_ROT_L, `CSB_OP_RTC_R, `CSB_OP_RTC_L: begin
                // see RL13 see RL14 see RL15 see RL16
                nxt_dest = {dest_ff[15:8], rot_out[7:0]};
                nxt_carry = rot_cy;
            end
            `CSB_OP_LSH_R, `CSB_OP_LSH_L: begin
                nxt_dest = {dest_ff[15:8], rot_out[7:0]}; // see RL17
                nxt_carry = rot_cy;
                nxt_nib = 1'b0;
                if (op == `CSB_OP_LSH_L) begin
                    nxt_zero = (rot_out[7:0] == 8'h00);
                end
            end
            `CSB_OP_PSH_R, `CSB_OP_PSH_L: begin
                nxt_dest = rot_out; // see RL18
                nxt_carry = rot_cy;
                nxt_nib = 1'b0;
                nxt_zero = (rot_out == 16'h0000);
            end
            `CSB_OP_NIB_R: begin
                // see RL19
                nxt_dest = {dest_ff[15:12], b8[3:0], dest_ff[7:0]};
                nxt_src = {src_ff[15:8], dest_ff[11:8], b8[7:4]};
            end
            `CSB_OP_NIB_L: begin
                // see RL20
                nxt_dest = {dest_ff[15:12], b8[7:4], dest_ff[7:0]};
                nxt_src = {src_ff[15:8], b8[3:0], dest_ff[11:8]};
            end
            `CSB_OP_DAA_ADD: begin
                nxt_dest = {dest_ff[15:8], daa_r[7:0]}; // see RL21
                nxt_carry = daa_hi | daa_r[8];
                nxt_nib = daa_n[4];
                nxt_zero = (daa_r[7:0] == 8'h00);
            end
            `CSB_OP_DAA_SUB: begin
                nxt_dest = {dest_ff[15:8], das_r}; // see RL21
                nxt_nib = das_n[4];
                nxt_zero = (das_r == 8'h00);
            end
            `CSB_OP_BIT_MOVE: begin
                nxt_carry = src_ff[cnt];
            end
            `CSB_OP_BIT_AND: begin
                nxt_carry = carry_ff & sel_bit; // see RL22
            end
            default: begin
                nxt_bad = 1'b1;
            end
        endcase
    end

    // ****************
    // write channels
    // ****************
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `CSB_RESP_OKAY;
        end else begin
            // address and data latched independently, in either order
            if (s_axi_awvalid & awready_ff) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
                awready_ff <= 1'b0;
            end else if (!aw_hold_ff) begin
                awready_ff <= 1'b1;
            end
            if (s_axi_wvalid & wready_ff) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end else if (!w_hold_ff) begin
                wready_ff <= 1'b1;
            end
            if (do_write) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
            end else if (bvalid_ff & s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ****************
    // datapath registers
    // ****************
    always @(posedge aclk) begin
        if (!aresetn) begin
            dest_ff <= `CSB_RST_WORD;
            src_ff <= `CSB_RST_WORD;
            carry_ff <= 1'b0;
            nib_ff <= 1'b0;
            zero_ff <= 1'b0;
            cmd_ff <= `CSB_RST_CMD;
            count_ff <= `CSB_RST_COUNT;
            bad_ff <= 1'b0;
        end else begin
            if (exec) begin
                dest_ff <= nxt_dest;
                src_ff <= nxt_src;
                carry_ff <= nxt_carry;
                nib_ff <= nxt_nib;
                zero_ff <= nxt_zero;
                cmd_ff <= wdata_ff[11:0];
                count_ff <= count_ff + 16'h0001;
            end
            if (wr_dest & wstrb_ff[0]) begin
                dest_ff[7:0] <= wdata_ff[7:0];
            end
            if (wr_dest & wstrb_ff[1]) begin
                dest_ff[15:8] <= wdata_ff[15:8];
            end
            if (wr_src & wstrb_ff[0]) begin
                src_ff[7:0] <= wdata_ff[7:0];
            end
            if (wr_src & wstrb_ff[1]) begin
                src_ff[15:8] <= wdata_ff[15:8];
            end
            if (wr_flags) begin
                carry_ff <= wdata_ff[`CSB_FLAG_CARRY];
                nib_ff <= wdata_ff[`CSB_FLAG_NIB];
                zero_ff <= wdata_ff[`CSB_FLAG_ZERO];
            end
            // set beats a clear in the same cycle; they never coincide
            // today since both need a bus write, kept for safety
            if (exec & nxt_bad) begin
                bad_ff <= 1'b1;
            end else if (wr_stat & wstrb_ff[2] & wdata_ff[`CSB_STAT_BAD]) begin
                bad_ff <= 1'b0;
            end
        end
    end

    // ****************
    // read channel
    // ****************
    reg [31:0] rd_mux;
    reg rd_hit;

    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            `CSB_OFF_DEST: rd_mux = {16'h0000, dest_ff};
            `CSB_OFF_SRC: rd_mux = {16'h0000, src_ff};
            `CSB_OFF_FLAGS: rd_mux = {29'h0000_0000, zero_ff, nib_ff, carry_ff};
            `CSB_OFF_CMD: rd_mux = {20'h0_0000, cmd_ff};
            `CSB_OFF_STATUS: rd_mux = {15'h0000, bad_ff, count_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `CSB_RESP_OKAY;
        end else begin
            if (s_axi_arvalid & arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
            end else if (rvalid_ff & s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end else if (!rvalid_ff) begin
                arready_ff <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule

// [rtl/csb_alu_map.vh]
// register map, field positions, reset values and operation codes of the
// alu datapath; included by every design file but the divider, holds definitions only
`ifndef CSB_ALU_MAP_VH
`define CSB_ALU_MAP_VH

// ****************
// register byte offsets
// ****************
`define CSB_OFF_DEST 8'h00
`define CSB_OFF_SRC 8'h04
`define CSB_OFF_FLAGS 8'h08
`define CSB_OFF_CMD 8'h0C
`define CSB_OFF_STATUS 8'h10

// ****************
// reset values
// ****************
`define CSB_RST_WORD 16'h0000
`define CSB_RST_CMD 12'h000
`define CSB_RST_COUNT 16'h0000

// ****************
// field positions
// ****************
`define CSB_FLAG_CARRY 0
`define CSB_FLAG_NIB 1
`define CSB_FLAG_ZERO 2
`define CSB_CMD_OP_LSB 0
`define CSB_CMD_OP_MSB 4
`define CSB_CMD_CNT_LSB 8
`define CSB_CMD_CNT_MSB 10
`define CSB_CMD_INV 11
`define CSB_STAT_BAD 16

// ****************
// bus responses
// ****************
`define CSB_RESP_OKAY 2'h0
`define CSB_RESP_SLVERR 2'h2

// ****************
// rotator modes
// ****************
`define CSB_RMODE_ROT 2'h0
`define CSB_RMODE_RTC 2'h1
`define CSB_RMODE_ZERO 2'h2

// ****************
// operation codes
// ****************
`define CSB_OP_ADD 5'h00
`define CSB_OP_ADD_CY 5'h01
`define CSB_OP_SUB 5'h02
`define CSB_OP_SUB_BW 5'h03
`define CSB_OP_AND 5'h04
`define CSB_OP_OR 5'h05
`define CSB_OP_XOR 5'h06
`define CSB_OP_BCOMP 5'h07
`define CSB_OP_WADD 5'h08
`define CSB_OP_WSUB 5'h09
`define CSB_OP_WCOMP 5'h0A
`define CSB_OP_MUL 5'h0B
`define CSB_OP_DIV 5'h0C
`define CSB_OP_INC 5'h0D
`define CSB_OP_DEC 5'h0E
`define CSB_OP_PINC 5'h0F
`define CSB_OP_PDEC 5'h10
`define CSB_OP_ROT_R 5'h11
`define CSB_OP_ROT_L 5'h12
`define CSB_OP_RTC_R 5'h13
`define CSB_OP_RTC_L 5'h14
`define CSB_OP_LSH_R 5'h15
`define CSB_OP_LSH_L 5'h16
`define CSB_OP_PSH_R 5'h17
`define CSB_OP_PSH_L 5'h18
`define CSB_OP_NIB_R 5'h19
`define CSB_OP_NIB_L 5'h1A
`define CSB_OP_DAA_ADD 5'h1B
`define CSB_OP_DAA_SUB 5'h1C
`define CSB_OP_BIT_MOVE 5'h1D
`define CSB_OP_BIT_AND 5'h1E

`endif

// [rtl/csb_rotator.v]
// multi-step byte or word rotate and shift, purely combinational
// assumes the caller holds the count at 0 to 7 and, in byte mode, the data in the low byte
`timescale 1ns/100ps
`include "csb_alu_map.vh"

module csb_rotator #(
    parameter STEPS = 7
) (
    input wire [15:0] din,
    input wire cin,
    input wire wide,
    input wire [1:0] mode,
    input wire left,
    input wire [2:0] count,
    output wire [15:0] dout,
    output wire cout
);

    wire [16:0] stage [0:STEPS];

    assign stage[0] = {cin, din};

    // ****************
    // one stage per possible step
    // ****************
    genvar i;
    generate
        for (i = 0; i < STEPS; i = i + 1) begin : g_step
            localparam [2:0] IDX = i;
            wire [15:0] d = stage[i][15:0];
            wire c = stage[i][16];
            wire out_bit = left ? (wide ? d[15] : d[7]) : d[0];
            wire fill = (mode == `CSB_RMODE_ROT) ? out_bit :
                        ((mode == `CSB_RMODE_RTC) ? c : 1'b0);
            wire [15:0] moved = left ?
                (wide ? {d[14:0], fill} : {8'h00, d[6:0], fill}) :
                (wide ? {fill, d[15:1]} : {8'h00, fill, d[7:1]});
            // a zero count leaves data and carry untouched
            assign stage[i+1] = (IDX < count) ? {out_bit, moved} : stage[i];
        end
    endgenerate

    assign dout = stage[STEPS][15:0];
    assign cout = stage[STEPS][16];

endmodule

// [rtl/csb_divider.v]
// unsigned restoring divider, one generate stage per quotient bit
// assumes a non-zero divisor; the caller handles division by zero
`timescale 1ns/100ps

module csb_divider #(
    parameter DW = 16,
    parameter VW = 8
) (
    input wire [DW-1:0] dividend,
    input wire [VW-1:0] divisor,
    output wire [DW-1:0] quotient,
    output wire [VW-1:0] remainder
);

    wire [VW-1:0] part [0:DW];

    assign part[0] = {VW{1'b0}};

    genvar i;
    generate
        for (i = 0; i < DW; i = i + 1) begin : g_bit
            wire [VW:0] trial = {part[i], dividend[DW-1-i]};
            wire fits = (trial >= {1'b0, divisor});
            wire [VW:0] diff = trial - {1'b0, divisor};
            assign quotient[DW-1-i] = fits;
            assign part[i+1] = fits ? diff[VW-1:0] : trial[VW-1:0];
        end
    endgenerate

    assign remainder = part[DW];

endmodule

// [sim/csb_alu_top_assertions.sv]
// handshake checks on the alu datapath bus ports
// assumes one clock, a read answer one cycle and a write answer two cycles after the take
`timescale 1ns/100ps
`include "csb_alu_map.vh"
module csb_alu_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    // ****************
    // bus handshakes
    // ****************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_done;
        s_axi_bvalid && s_axi_bready;
    endsequence
    chk_b_follows: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_b_reopen: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write path not reopened");
    chk_aw_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    chk_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data changed");
    chk_r_reopen: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
        && s_axi_arready) else $error("read path not reopened");
    chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == `CSB_RESP_SLVERR
        |-> s_axi_rdata == 32'h0000_0000) else $error("error read carries data");
endmodule
bind csb_alu_top csb_alu_chk u_chk (.*);

// [sim/csb_bus_master.sv]
// bus master standing in for the core decoder, driven by bench calls
// assumes one call at a time, started after reset release
`timescale 1ns/100ps
module csb_bus_master (
    input wire aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready
);
    // ****************
    // bus cycles
    // ****************
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr} = 16'h0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
    end
    // valids drop only on their own take, never early
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// [sim/csb_alu_top_bench.sv]
// self-checking bench: operands in, one command, results read back
// assumes rtl/ on the include path and the bus master model beside it
`timescale 1ns/100ps
`include "csb_alu_map.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module csb_alu_top_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int checks = 0, miscompares = 0, n = 0, cyc = 0;
    csb_alu_top uut (.*);
    csb_bus_master m (.*);
    // ****************
    // helpers
    // ****************
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict;
        end
    end
    task t(input logic [11:0] c, input logic [15:0] d, s, input logic [2:0] f,
           input logic [15:0] ed, es, input logic [2:0] ef);
        n++;
        m.wr(`CSB_OFF_DEST, {16'h0000, d}, rs);
        m.wr(`CSB_OFF_SRC, {16'h0000, s}, rs);
        m.wr(`CSB_OFF_FLAGS, {29'h0, f}, rs);
        m.wr(`CSB_OFF_CMD, {20'h0_0000, c}, rs);
        m.rd(`CSB_OFF_DEST, rv, rs);
        `CHK("dest", {16'h0000, ed}, rv);
        m.rd(`CSB_OFF_SRC, rv, rs);
        `CHK("src", {16'h0000, es}, rv);
        m.rd(`CSB_OFF_FLAGS, rv, rs);
        `CHK("flags", {29'h0, ef}, rv);
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        m.rd(`CSB_OFF_STATUS, rv, rs);
        `CHK("status", 32'h0000_0000, rv);
        t(12'h000, 16'h0088, 16'h0078, 3'h0, 16'h0000, 16'h0078, 3'h7);
        t(12'h001, 16'h0010, 16'h0020, 3'h1, 16'h0031, 16'h0020, 3'h0);
        t(12'h002, 16'h0010, 16'h0001, 3'h0, 16'h000F, 16'h0001, 3'h2);
        t(12'h003, 16'h0000, 16'h0000, 3'h1, 16'h00FF, 16'h0000, 3'h3);
        t(12'h004, 16'h00F0, 16'h000F, 3'h3, 16'h0000, 16'h000F, 3'h7);
        t(12'h00A, 16'h1000, 16'h2000, 3'h0, 16'h1000, 16'h2000, 3'h1);
        t(12'h008, 16'hFFFF, 16'h0001, 3'h0, 16'h0000, 16'h0001, 3'h7);
        t(12'h00B, 16'h0F00, 16'h0010, 3'h5, 16'h00F0, 16'h0010, 3'h5);
        t(12'h00C, 16'h0064, 16'h0007, 3'h2, 16'h000E, 16'h0002, 3'h2);
        t(12'h00C, 16'h1234, 16'h0000, 3'h0, 16'hFFFF, 16'h0034, 3'h0);
        t(12'h00D, 16'h00FF, 16'h0000, 3'h1, 16'h0000, 16'h0000, 3'h7);
        t(12'h010, 16'h0000, 16'h0000, 3'h5, 16'hFFFF, 16'h0000, 3'h5);
        t(12'h111, 16'h0001, 16'h0000, 3'h0, 16'h0080, 16'h0000, 3'h1);
        t(12'h712, 16'h0081, 16'h0000, 3'h1, 16'h00C0, 16'h0000, 3'h0);
        t(12'h213, 16'h0003, 16'h0000, 3'h0, 16'h0080, 16'h0000, 3'h1);
        t(12'h114, 16'h0080, 16'h0000, 3'h0, 16'h0000, 16'h0000, 3'h1);
        t(12'h315, 16'h0005, 16'h0000, 3'h6, 16'h0000, 16'h0000, 3'h5);
        t(12'h718, 16'h0101, 16'h0000, 3'h4, 16'h8080, 16'h0000, 3'h0);
        t(12'h019, 16'h0300, 16'h00AB, 3'h0, 16'h0B00, 16'h003A, 3'h0);
        t(12'h01A, 16'h0300, 16'h00AB, 3'h0, 16'h0A00, 16'h00B3, 3'h0);
        t(12'h01B, 16'h000C, 16'h0000, 3'h0, 16'h0012, 16'h0000, 3'h2);
        t(12'hA1E, 16'h0000, 16'h0000, 3'h1, 16'h0000, 16'h0000, 3'h1);
        m.rd(`CSB_OFF_STATUS, rv, rs);
        `CHK("op count", {16'h0000, n[15:0]}, rv);
        m.rd(8'h14, rv, rs);
        `CHK("hole rresp", `CSB_RESP_SLVERR, rs);
        m.wr(8'h14, 32'h0000_0000, rs);
        `CHK("hole bresp", `CSB_RESP_SLVERR, rs);
        print_verdict;
    end
endmodule
